/* common/dap_consts.svh */
// register map, field positions, codes and timing counts of the disk adapter host port
`ifndef DAP_CONSTS_SVH
`define DAP_CONSTS_SVH

`define DAP_OFS_IRQ_CTRL     12'h3F6
`define DAP_OFS_ERRA_STACK   12'h5F0
`define DAP_OFS_MODE         12'h5F3
`define DAP_OFS_ERRB         12'h5F4
`define DAP_OFS_STAT_CMD     12'h5F6
`define DAP_SEC_MASK         12'hF7F

`define DAP_MODE_DMA_BIT     0
`define DAP_CTRL_ALT_DMA     3
`define DAP_CTRL_RUN         2
`define DAP_CTRL_IRQ_OFF     1
`define DAP_CTRL_IRQ_ALT     0
`define DAP_ISR_DISK_BIT     7
`define DAP_ISR_FLOPPY_BIT   6
`define DAP_DRVHEAD_RST      8'hA0

`define DAP_DMA_CH_PRI       2'h0
`define DAP_DMA_CH_SEC       2'h3
`define DAP_DMA_CH_ALT       2'h1
`define DAP_BURST_ADVISED    3'h2

`define DAP_ERR_NONE         8'h00
`define DAP_ERR_NO_AM        8'h01
`define DAP_ERR_TRK0         8'h02
`define DAP_ERR_ABORT        8'h04
`define DAP_ERR_ADAPTER      8'h08
`define DAP_ERR_IDNF         8'h10
`define DAP_ERR_WFAULT       8'h20
`define DAP_ERR_ECC          8'h40
`define DAP_ERR_BADBLK       8'h80
`define DAP_ERR_BADBLK_ALT   8'hC0
`define DAP_ERR_WPARITY      8'h21
`define DAP_ERR_INVALID      8'h24

`define DAP_OP_RD_FILE       8'h20
`define DAP_OP_RD_FILE_MASK  8'hF6
`define DAP_OP_WR_FILE       8'h30
`define DAP_OP_VERIFY        8'h40
`define DAP_OP_R_MASK        8'hFE
`define DAP_OP_RESTORE       8'h10
`define DAP_OP_RD_BUF        8'h71
`define DAP_OP_WR_BUF        8'h72
`define DAP_OP_SHUTDOWN      8'hF0
`define DAP_LO_BUF           8'h06
`define DAP_SLOT_LAST_FILE   3'h5

`define DAP_STACK_DEPTH      5

`define DAP_CLK_PERIOD_NS    4
`define DAP_DIAG_TIME_NS     2000
`define DAP_DIAG_CYCLES      ((`DAP_DIAG_TIME_NS + `DAP_CLK_PERIOD_NS - 1) / `DAP_CLK_PERIOD_NS)
`define DAP_SETTLE_TIME_MS   100
`define DAP_SETTLE_CYCLES    ((`DAP_SETTLE_TIME_MS * 1000000) / `DAP_CLK_PERIOD_NS)

`define DAP_HOFS_IO_WRITE    4'h0
`define DAP_HOFS_RD_ADDR     4'h4
`define DAP_HOFS_IO_READ     4'h8
`define DAP_HOFS_STATUS      4'hC

`endif

/* common/dap_pkg.sv */
// types of the disk adapter host port: the data word used by both ends and the state codes of the host end
package dap_pkg;

    typedef logic [15:0] dap_word_t;

    typedef enum logic [2:0] {
        HS_IDLE = 3'h1,
        HS_IO   = 3'h2,
        HS_DONE = 3'h4
    } dap_hstate_e;

endpackage

/* common/dap_if.sv */
// i/o port between host processor end and disk adapter end
`timescale 1ns/1ps
interface dap_if;
    logic [11:0]       addr;
    logic [1:0]        be;
    logic              rd;
    logic              wr;
    dap_pkg::dap_word_t wdata;
    dap_pkg::dap_word_t rdata;
    logic              ack;
    logic              irq_l14;
    logic              irq_l12;

    modport dev  (input addr, be, rd, wr, wdata, output rdata, ack, irq_l14, irq_l12);
    modport host (output addr, be, rd, wr, wdata, input rdata, ack, irq_l14, irq_l12);
endinterface

/* design/dap_device.sv */
// adapter end: DMA-mode register set, command intake, status and interrupt routing
`timescale 1ns/1ps
`include "dap_consts.svh"

module dap_device #(
    parameter bit          SECONDARY   = 1'b0,
    parameter int unsigned DIAG_CYCLES = `DAP_DIAG_CYCLES
) (
    input  wire logic        clk,
    input  wire logic        sys_rst,
    dap_if.dev               io,
    output logic             cmd_valid,
    output logic [15:0]      cmd_word,
    output logic [79:0]      cmd_params,
    input  wire logic        cmd_ready,
    input  wire logic        done_valid,
    input  wire logic [2:0]  done_slot,
    input  wire logic [7:0]  done_code,
    input  wire logic        done_corrected,
    input  wire logic [15:0] done_err_a,
    input  wire logic [15:0] done_err_b,
    input  wire logic        diskette_irq,
    output logic             dma_mode,
    output logic [2:0]       burst_sel,
    output logic [1:0]       dma_chan,
    output logic [7:0]       drive_head,
    output logic             diag_active
);

    logic        ack_ff;
    logic [15:0] rdata_ff;
    logic [7:0]  ctrl_ff;
    logic [7:0]  mode_ff;
    logic        busy_ff;
    logic        rej_ff;
    logic        valid_ff;
    logic        corr_ff;
    logic [2:0]  qslot_ff;
    logic [7:0]  code_ff;
    logic [15:0] erra_ff;
    logic [15:0] errb_ff;
    logic [15:0] stack_ff [`DAP_STACK_DEPTH];
    logic [2:0]  sp_ff;
    logic [7:0]  used_ff;
    logic        cmd_valid_ff;
    logic [15:0] cmd_word_ff;
    logic [15:0] diag_cnt_ff;
    logic        irq14_ff;
    logic        irq12_ff;
    logic [1:0]  chan_ff;
    logic [7:0]  drvhd_ff;
    logic        diag_ff;
    logic [2:0]  burst_ff;

    logic        take;
    logic        blocked;
    logic        soft_rst;
    logic        wr_stack;
    logic        wr_mode;
    logic        wr_cmd;
    logic        rd_stat_lo;
    logic        diag_end;
    logic        pend;
    logic [7:0]  hi;
    logic [7:0]  lo;
    logic        file_ok;
    logic        buf_ok;
    logic        shut_ok;
    logic [2:0]  new_slot;
    logic        conflict;
    logic        accept;
    logic        reject;

    function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
        return a == (SECONDARY ? (ofs & `DAP_SEC_MASK) : ofs);
    endfunction

    // an access is acted on once, in the cycle before its acknowledge
    assign take       = (io.rd | io.wr) & ~ack_ff;
    assign blocked    = busy_ff | (diag_cnt_ff != 16'h0000);
    assign soft_rst   = take & io.wr & hit(io.addr, `DAP_OFS_IRQ_CTRL) & io.be[0]
                        & ~io.wdata[`DAP_CTRL_RUN];
    assign wr_stack   = take & io.wr & hit(io.addr, `DAP_OFS_ERRA_STACK) & ~blocked
                        & (io.be == 2'h3);
    assign wr_mode    = take & io.wr & hit(io.addr, `DAP_OFS_MODE) & ~blocked & io.be[0];
    assign wr_cmd     = take & io.wr & hit(io.addr, `DAP_OFS_STAT_CMD) & ~blocked
                        & (io.be == 2'h3);
    assign rd_stat_lo = take & io.rd & hit(io.addr, `DAP_OFS_STAT_CMD) & (io.be == 2'h1);
    assign diag_end   = diag_cnt_ff == 16'h0001;
    assign pend       = valid_ff & ~ctrl_ff[`DAP_CTRL_IRQ_OFF];

    always_comb begin
        hi       = io.wdata[15:8];
        lo       = io.wdata[7:0];
        file_ok  = (((hi & `DAP_OP_RD_FILE_MASK) == `DAP_OP_RD_FILE)
                    | ((hi & `DAP_OP_R_MASK) == `DAP_OP_WR_FILE)
                    | ((hi & `DAP_OP_R_MASK) == `DAP_OP_VERIFY)
                    | (hi == `DAP_OP_RESTORE))
                   & (lo[7:3] == 5'h00) & (lo[2:0] <= `DAP_SLOT_LAST_FILE);
        buf_ok   = ((hi == `DAP_OP_RD_BUF) | (hi == `DAP_OP_WR_BUF))
                   & ((lo & `DAP_OP_R_MASK) == `DAP_LO_BUF);
        shut_ok  = (hi == `DAP_OP_SHUTDOWN) & (lo == 8'h00);
        new_slot = buf_ok ? {2'h3, lo[0]} : lo[2:0];
        // a slot still holding an unfinished command cannot take another
        conflict = (file_ok | buf_ok) & used_ff[new_slot];
        accept   = wr_cmd & (file_ok | buf_ok | shut_ok) & ~conflict;
        reject   = wr_cmd & ~accept;
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            ack_ff <= 1'b0;
        end else begin
            ack_ff <= take;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            ctrl_ff  <= 8'h00;
            drvhd_ff <= `DAP_DRVHEAD_RST;
        end else if (take & io.wr & hit(io.addr, `DAP_OFS_IRQ_CTRL) & io.be[0]) begin
            ctrl_ff  <= io.wdata[7:0];
            drvhd_ff <= io.wdata[`DAP_CTRL_RUN] ? drvhd_ff : `DAP_DRVHEAD_RST;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            mode_ff  <= 8'h00;
            burst_ff <= 3'h0;
        end else if (soft_rst | (accept & shut_ok)) begin
            mode_ff  <= 8'h00;
            burst_ff <= 3'h0;
        end else if (wr_mode) begin
            mode_ff  <= io.wdata[7:0];
            burst_ff <= io.wdata[`DAP_MODE_DMA_BIT] ? io.wdata[3:1] : 3'h0;
        end
    end

    // diagnostics hold the adapter busy after every reset
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            diag_cnt_ff <= 16'(DIAG_CYCLES);
            diag_ff     <= 1'b1;
        end else if (soft_rst) begin
            diag_cnt_ff <= 16'(DIAG_CYCLES);
            diag_ff     <= 1'b1;
        end else if (diag_cnt_ff != 16'h0000) begin
            diag_cnt_ff <= diag_cnt_ff - 16'h0001;
            diag_ff     <= ~diag_end;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            busy_ff <= 1'b0;
            rej_ff  <= 1'b0;
        end else if (soft_rst) begin
            busy_ff <= 1'b0;
            rej_ff  <= 1'b0;
        end else begin
            rej_ff <= reject;
            if (wr_cmd) begin
                busy_ff <= 1'b1;
            end else if ((cmd_valid_ff & cmd_ready) | rej_ff) begin
                busy_ff <= 1'b0;
            end
        end
    end

    // the stack is not copied: busy keeps it frozen until the engine has taken it
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            sp_ff <= 3'h0;
        end else if (soft_rst | wr_cmd) begin
            sp_ff <= 3'h0;
        end else if (wr_stack & (sp_ff < 3'(`DAP_STACK_DEPTH))) begin
            sp_ff <= sp_ff + 3'h1;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < `DAP_STACK_DEPTH; gi++) begin : g_stack
            always_ff @(posedge clk or posedge sys_rst) begin
                if (sys_rst) begin
                    stack_ff[gi] <= 16'h0000;
                end else if (soft_rst) begin
                    stack_ff[gi] <= 16'h0000;
                end else if (wr_stack & (sp_ff == 3'(gi))) begin
                    stack_ff[gi] <= io.wdata;
                end
            end
            assign cmd_params[gi*16 +: 16] = stack_ff[gi];
        end
    endgenerate

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            cmd_valid_ff <= 1'b0;
            cmd_word_ff  <= 16'h0000;
        end else if (soft_rst) begin
            cmd_valid_ff <= 1'b0;
            cmd_word_ff  <= 16'h0000;
        end else if (accept) begin
            cmd_valid_ff <= 1'b1;
            cmd_word_ff  <= io.wdata;
        end else if (cmd_ready) begin
            cmd_valid_ff <= 1'b0;
        end
    end

    // occupancy of the eight queue slots; a set in the same cycle beats the clear
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            used_ff <= 8'h00;
        end else if (soft_rst) begin
            used_ff <= 8'h00;
        end else begin
            for (int i = 0; i < 8; i++) begin
                if (accept & ~shut_ok & (new_slot == 3'(i))) begin
                    used_ff[i] <= 1'b1;
                end else if (done_valid & (done_slot == 3'(i))) begin
                    used_ff[i] <= 1'b0;
                end
            end
        end
    end

    // status posting: reject beats completion beats end of diagnostics
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            valid_ff <= 1'b0;
            corr_ff  <= 1'b0;
            qslot_ff <= 3'h0;
            code_ff  <= `DAP_ERR_NONE;
        end else if (soft_rst) begin
            valid_ff <= 1'b0;
            corr_ff  <= 1'b0;
            qslot_ff <= 3'h0;
            code_ff  <= `DAP_ERR_NONE;
        end else if (reject) begin
            valid_ff <= 1'b1;
            corr_ff  <= 1'b0;
            qslot_ff <= new_slot;
            code_ff  <= conflict ? `DAP_ERR_ABORT : `DAP_ERR_INVALID;
        end else if (done_valid) begin
            valid_ff <= 1'b1;
            corr_ff  <= done_corrected;
            qslot_ff <= done_slot;
            code_ff  <= done_code;
        end else if (diag_end) begin
            valid_ff <= 1'b1;
            code_ff  <= `DAP_ERR_NONE;
        end else if (rd_stat_lo) begin
            valid_ff <= 1'b0;
        end
    end

    // error details survive a soft reset
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            erra_ff <= 16'h0000;
            errb_ff <= 16'h0000;
        end else if (reject) begin
            erra_ff <= io.wdata;
        end else if (done_valid & (done_code != `DAP_ERR_NONE)) begin
            erra_ff <= done_err_a;
            errb_ff <= done_err_b;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            irq14_ff <= 1'b0;
            irq12_ff <= 1'b0;
            chan_ff  <= `DAP_DMA_CH_PRI;
        end else begin
            irq14_ff <= pend & ~ctrl_ff[`DAP_CTRL_IRQ_ALT];
            irq12_ff <= pend & ctrl_ff[`DAP_CTRL_IRQ_ALT];
            chan_ff  <= ctrl_ff[`DAP_CTRL_ALT_DMA] ? `DAP_DMA_CH_ALT
                        : (SECONDARY ? `DAP_DMA_CH_SEC : `DAP_DMA_CH_PRI);
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            rdata_ff <= 16'h0000;
        end else if (take & io.rd) begin
            if (hit(io.addr, `DAP_OFS_IRQ_CTRL)) begin
                rdata_ff <= 16'h0000;
                rdata_ff[`DAP_ISR_DISK_BIT]   <= pend;
                rdata_ff[`DAP_ISR_FLOPPY_BIT] <= diskette_irq;
            end else if (hit(io.addr, `DAP_OFS_ERRA_STACK)) begin
                rdata_ff <= erra_ff;
            end else if (hit(io.addr, `DAP_OFS_MODE)) begin
                rdata_ff <= {8'h00, mode_ff};
            end else if (hit(io.addr, `DAP_OFS_ERRB)) begin
                rdata_ff <= errb_ff;
            end else if (hit(io.addr, `DAP_OFS_STAT_CMD)) begin
                rdata_ff <= {blocked, valid_ff, corr_ff, 2'h0, qslot_ff, code_ff};
            end else begin
                rdata_ff <= 16'h0000;
            end
        end
    end

    assign io.ack      = ack_ff;
    assign io.rdata    = rdata_ff;
    assign io.irq_l14  = irq14_ff;
    assign io.irq_l12  = irq12_ff;
    assign cmd_valid   = cmd_valid_ff;
    assign cmd_word    = cmd_word_ff;
    assign dma_mode    = mode_ff[`DAP_MODE_DMA_BIT];
    assign burst_sel   = burst_ff;
    assign dma_chan    = chan_ff;
    assign drive_head  = drvhd_ff;
    assign diag_active = diag_ff;

endmodule

/* design/dap_host.sv */
// host end: Avalon-MM command port turned into adapter i/o cycles
`timescale 1ns/1ps
`include "dap_consts.svh"

module dap_host #(
    parameter int unsigned SETTLE_CYCLES = `DAP_SETTLE_CYCLES
) (
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic [3:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    dap_if.host              io
);

    dap_pkg::dap_hstate_e state_ff;
    logic        wait_ff;
    logic [31:0] rdata_ff;
    logic [11:0] addr_ff;
    logic [1:0]  be_ff;
    logic        rd_ff;
    logic        wr_ff;
    logic [15:0] wdata_ff;
    logic [13:0] rd_addr_ff;
    logic [31:0] settle_ff;
    logic        warn_ff;

    logic [11:0] tgt;
    logic        to_cmd;
    logic        take;
    logic        io_wr_go;
    logic        io_rd_go;

    // the port answers at either the primary or the secondary address block
    function automatic logic same(input logic [11:0] a, input logic [11:0] ofs);
        return (a & `DAP_SEC_MASK) == (ofs & `DAP_SEC_MASK);
    endfunction

    assign tgt      = avs_writedata[11:0];
    assign to_cmd   = same(tgt, `DAP_OFS_STAT_CMD) & (settle_ff != 32'h0);
    // a command write during settling is simply held off by waitrequest
    assign take     = (avs_read | avs_write) & (state_ff == dap_pkg::HS_IDLE) & wait_ff
                      & ~(avs_write & (avs_address == `DAP_HOFS_IO_WRITE) & to_cmd);
    assign io_wr_go = take & avs_write & (avs_address == `DAP_HOFS_IO_WRITE);
    assign io_rd_go = take & avs_read & (avs_address == `DAP_HOFS_IO_READ);

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_ff <= dap_pkg::HS_IDLE;
            wait_ff  <= 1'b1;
            rdata_ff <= 32'h0;
        end else begin
            unique case (state_ff)
                dap_pkg::HS_IDLE: begin
                    if (io_wr_go | io_rd_go) begin
                        state_ff <= dap_pkg::HS_IO;
                    end else if (take) begin
                        state_ff <= dap_pkg::HS_DONE;
                        wait_ff  <= 1'b0;
                        if (avs_read & (avs_address == `DAP_HOFS_RD_ADDR)) begin
                            rdata_ff <= {18'h0, rd_addr_ff};
                        end else if (avs_read & (avs_address == `DAP_HOFS_STATUS)) begin
                            rdata_ff <= {28'h0, warn_ff, settle_ff != 32'h0,
                                         io.irq_l12, io.irq_l14};
                        end else begin
                            rdata_ff <= 32'h0;
                        end
                    end
                end
                dap_pkg::HS_IO: begin
                    if (io.ack) begin
                        state_ff <= dap_pkg::HS_DONE;
                        wait_ff  <= 1'b0;
                        rdata_ff <= {16'h0, io.rdata};
                    end
                end
                dap_pkg::HS_DONE: begin
                    state_ff <= dap_pkg::HS_IDLE;
                    wait_ff  <= 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            addr_ff  <= 12'h000;
            be_ff    <= 2'h0;
            rd_ff    <= 1'b0;
            wr_ff    <= 1'b0;
            wdata_ff <= 16'h0000;
        end else if (io_wr_go) begin
            addr_ff  <= tgt;
            // stack words are only ever written whole
            be_ff    <= same(tgt, `DAP_OFS_ERRA_STACK) ? 2'h3 : avs_writedata[13:12];
            wr_ff    <= 1'b1;
            wdata_ff <= avs_writedata[31:16];
        end else if (io_rd_go) begin
            addr_ff  <= rd_addr_ff[11:0];
            be_ff    <= rd_addr_ff[13:12];
            rd_ff    <= 1'b1;
        end else if (io.ack) begin
            rd_ff <= 1'b0;
            wr_ff <= 1'b0;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            rd_addr_ff <= 14'h0000;
        end else if (take & avs_write & (avs_address == `DAP_HOFS_RD_ADDR)) begin
            rd_addr_ff <= avs_writedata[13:0];
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            settle_ff <= 32'h0;
            warn_ff   <= 1'b0;
        end else if (io_wr_go & same(tgt, `DAP_OFS_MODE)) begin
            settle_ff <= avs_writedata[16 + `DAP_MODE_DMA_BIT] ? 32'(SETTLE_CYCLES) : 32'h0;
            warn_ff   <= avs_writedata[16 + `DAP_MODE_DMA_BIT]
                         & (avs_writedata[19:17] > `DAP_BURST_ADVISED);
        end else if (settle_ff != 32'h0) begin
            settle_ff <= settle_ff - 32'h1;
        end
    end

    assign avs_readdata    = rdata_ff;
    assign avs_waitrequest = wait_ff;
    assign io.addr         = addr_ff;
    assign io.be           = be_ff;
    assign io.rd           = rd_ff;
    assign io.wr           = wr_ff;
    assign io.wdata        = wdata_ff;

endmodule

/* dv/dap_link_assertions.sv */
// link checks between the host end and the adapter end
`timescale 1ns/1ps
module dap_link_assertions (
    input wire logic        clk,
    input wire logic        sys_rst,
    input wire logic [11:0] addr,
    input wire logic [1:0]  be,
    input wire logic        rd,
    input wire logic        wr,
    input wire logic [15:0] wdata,
    input wire logic [15:0] rdata,
    input wire logic        ack,
    input wire logic        irq_l14,
    input wire logic        irq_l12
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    property p_answer; (rd || wr) && !ack |=> ack; endproperty
    property p_pulse; ack |=> !ack; endproperty
    property p_cause; ack |-> $past(rd || wr); endproperty
    property p_hold; (rd || wr) && !ack |=> $stable({addr, be, wdata, rd, wr}); endproperty
    property p_drop; ack |=> !rd && !wr; endproperty
    property p_excl; !(rd && wr); endproperty
    property p_stack; wr && addr == 12'h5F0 |-> be == 2'h3; endproperty
    property p_level; !(irq_l14 && irq_l12); endproperty
    a_answer: assert property (p_answer) else $error("request not answered");
    a_pulse: assert property (p_pulse) else $error("answer longer than one cycle");
    a_cause: assert property (p_cause) else $error("answer without request");
    a_hold: assert property (p_hold) else $error("request changed before answer");
    a_drop: assert property (p_drop) else $error("request kept after answer");
    a_excl: assert property (p_excl) else $error("read and write together");
    a_stack: assert property (p_stack) else $error("stack write not 16 bits");
    a_level: assert property (p_level) else $error("both interrupt levels");
    c_wr: cover property (wr && ack);
    c_rd: cover property (rd && ack);
    c_l12: cover property (irq_l12);
endmodule

/* dv/test_disk_adapter_dma_host_port.sv */
// bench: both ends joined, driven from the avalon side and the engine side
`timescale 1ns/1ps
`include "dap_consts.svh"
module test_disk_adapter_dma_host_port;
    localparam logic [11:0] st = `DAP_OFS_STAT_CMD;
    localparam logic [11:0] sk = `DAP_OFS_ERRA_STACK;
    localparam logic [11:0] ct = `DAP_OFS_IRQ_CTRL;
    logic        clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic [3:0]  avs_address = 4'h0;
    logic        avs_read = 1'b0, avs_write = 1'b0, cmd_ready = 1'b0, done_valid = 1'b0;
    logic        done_corrected = 1'b0, diskette_irq = 1'b1;
    logic        avs_waitrequest, cmd_valid, dma_mode, diag_active;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
    logic [2:0]  done_slot = 3'h0, burst_sel, s;
    logic [7:0]  done_code = 8'h00, drive_head;
    logic [15:0] done_err_a = 16'h0, done_err_b = 16'h0, cmd_word, word, ea, eb, w [5];
    logic [79:0] cmd_params;
    logic [1:0]  dma_chan;
    int          seed = 32'h07B160C4, mismatches = 0, n_compared = 0;
    dap_if link ();
    dap_device #(.DIAG_CYCLES(4)) u_dap_device (.clk, .sys_rst, .io(link.dev), .cmd_valid,
        .cmd_word, .cmd_params, .cmd_ready, .done_valid, .done_slot, .done_code,
        .done_corrected, .done_err_a, .done_err_b, .diskette_irq, .dma_mode, .burst_sel,
        .dma_chan, .drive_head, .diag_active);
    dap_host #(.SETTLE_CYCLES(20)) u_dap_host (.clk, .sys_rst, .avs_address, .avs_read,
        .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest, .io(link.host));
    dap_link_assertions u_chk (.clk, .sys_rst, .addr(link.addr), .be(link.be), .rd(link.rd),
        .wr(link.wr), .wdata(link.wdata), .rdata(link.rdata), .ack(link.ack),
        .irq_l14(link.irq_l14), .irq_l12(link.irq_l12));
    always #2 clk = ~clk;
    task automatic print_verdict;
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask
    // the extra edge after release keeps two requests from landing in one time step
    task automatic av(input logic wt, input logic [3:0] a, input logic [31:0] d);
        avs_address <= a;
        avs_write <= wt;
        avs_read <= !wt;
        avs_writedata <= d;
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge clk);
    endtask
    task automatic io_wr(input logic [11:0] a, input logic [15:0] d, input logic [1:0] b);
        av(1'b1, `DAP_HOFS_IO_WRITE, {d, 2'b00, b, a});
    endtask
    task automatic io_rd(input logic [11:0] a, input logic [1:0] b);
        av(1'b1, `DAP_HOFS_RD_ADDR, {18'h0, b, a});
        av(1'b0, `DAP_HOFS_IO_READ, 32'h0);
    endtask
    task automatic wait_idle;
        do io_rd(st, 2'h3); while (q[15] !== 1'b0);
    endtask
    task automatic take_cmd(input logic [15:0] e);
        chk("cmd_word", e, cmd_word);
        cmd_ready <= 1'b1;
        @(posedge clk);
        cmd_ready <= 1'b0;
    endtask
    function automatic logic [15:0] stat(logic v, logic c, logic [2:0] sl, logic [7:0] e);
        return {1'b0, v, c, 2'b00, sl, e};
    endfunction
    initial begin
        #200000;
        mismatches++;
        print_verdict();
    end
    initial begin
        repeat (3) @(posedge clk);
        chk("drive_head", 8'hA0, drive_head);
        chk("diag_active", 1'b1, diag_active);
        sys_rst <= 1'b0;
        @(posedge clk);
        while (diag_active !== 1'b0) @(posedge clk);
        io_rd(st, 2'h3);
        chk("status", stat(1'b1, 1'b0, 3'h0, `DAP_ERR_NONE), q[15:0]);
        av(1'b0, `DAP_HOFS_STATUS, 32'h0);
        chk("irq_l14", 1'b1, q[0]);
        io_rd(st, 2'h1);
        io_rd(st, 2'h3);
        chk("status", stat(1'b0, 1'b0, 3'h0, `DAP_ERR_NONE), q[15:0]);
        for (int b = 0; b < 8; b++) begin
            io_wr(`DAP_OFS_MODE, {12'h0, b[2:0], 1'b1}, 2'h1);
            chk("burst_sel", b, burst_sel);
            av(1'b0, `DAP_HOFS_STATUS, 32'h0);
            chk("burst_flag", b > 2, q[3]);
            chk("settling", 1'b1, q[2]);
        end
        chk("dma_mode", 1'b1, dma_mode);
        for (int i = 0; i < 5; i++) begin
            w[i] = 16'($random(seed));
            io_wr(sk, w[i], 2'h3);
        end
        s = 3'($unsigned($random(seed)) % 6);
        word = {4'h2, 1'($random(seed)), 2'b00, 1'($random(seed)), 5'h00, s};
        io_wr(st, word, 2'h3);
        while (cmd_valid !== 1'b1) @(posedge clk);
        io_wr(sk, ~w[0], 2'h3);
        io_wr(`DAP_OFS_MODE, 16'h0000, 2'h1);
        chk("dma_mode", 1'b1, dma_mode);
        for (int i = 0; i < 5; i++) chk("cmd_params", w[i], cmd_params[16*i +: 16]);
        take_cmd(word);
        wait_idle();
        w[0] = 16'($random(seed));
        io_wr(sk, w[0], 2'h3);
        word = {`DAP_OP_RESTORE, 5'h00, s ^ 3'h1};
        io_wr(st, word, 2'h3);
        while (cmd_valid !== 1'b1) @(posedge clk);
        chk("cmd_params", w[0], cmd_params[15:0]);
        take_cmd(word);
        wait_idle();
        io_wr(st, word, 2'h3);
        wait_idle();
        chk("status", stat(1'b1, 1'b0, s ^ 3'h1, `DAP_ERR_ABORT), q[15:0]);
        // reserved slot field: must come back as an invalid command
        io_wr(st, 16'h2006, 2'h3);
        wait_idle();
        chk("status", stat(1'b1, 1'b0, 3'h6, `DAP_ERR_INVALID), q[15:0]);
        io_rd(sk, 2'h3);
        chk("error_a", 16'h2006, q[15:0]);
        ea = 16'($random(seed));
        eb = 16'($random(seed));
        done_slot <= s;
        done_code <= `DAP_ERR_ECC;
        done_corrected <= 1'b1;
        done_err_a <= ea;
        done_err_b <= eb;
        done_valid <= 1'b1;
        @(posedge clk);
        done_valid <= 1'b0;
        io_rd(st, 2'h3);
        chk("status", stat(1'b1, 1'b1, s, `DAP_ERR_ECC), q[15:0]);
        io_rd(`DAP_OFS_ERRB, 2'h3);
        chk("error_b", eb, q[15:0]);
        word = {(s[0] ? `DAP_OP_WR_BUF : `DAP_OP_RD_BUF), 7'h03, s[1]};
        io_wr(st, word, 2'h3);
        take_cmd(word);
        io_wr(ct, 16'h000D, 2'h1);
        chk("dma_chan", `DAP_DMA_CH_ALT, dma_chan);
        av(1'b0, `DAP_HOFS_STATUS, 32'h0);
        chk("irq_levels", 2'h2, q[1:0]);
        io_rd(ct, 2'h1);
        chk("irq_status", 8'hC0, q[7:0]);
        diskette_irq <= 1'b0;
        io_rd(ct, 2'h1);
        chk("irq_status", 8'h80, q[7:0]);
        io_wr(ct, 16'h0004, 2'h1);
        chk("dma_chan", `DAP_DMA_CH_PRI, dma_chan);
        io_wr(ct, 16'h0000, 2'h1);
        chk("dma_mode", 1'b0, dma_mode);
        while (diag_active !== 1'b0) @(posedge clk);
        io_rd(sk, 2'h3);
        chk("error_a", ea, q[15:0]);
        io_wr(`DAP_OFS_MODE, 16'h0001, 2'h1);
        chk("dma_mode", 1'b1, dma_mode);
        io_wr(st, 16'hF000, 2'h3);
        take_cmd(16'hF000);
        chk("dma_mode", 1'b0, dma_mode);
        print_verdict();
    end
endmodule
